// *** eeac_controller.v ***
// Access controller for a 512-byte nonvolatile data store, I/O mapped.
// Assumes the CPU I/O bus is synchronous to core_clk, that io_write and
// io_read are one-cycle strobes, and that the array commits a byte on a
// one-cycle nv_write_req and returns read data combinationally.
//
// What this block and its software do
// R1: 9-bit linear address, locations 0 to 511
// R2: Address bits 15..9 ignore writes, read zero
// R3: Address undefined at reset; software loads first
// R4: Data register holds write byte, read result
// R5: Control bits 7..4 ignore writes, read zero
// R6: Ready interrupt while enabled and strobe clear
// R7: Master write enable self-clears after four cycles
// R8: Write strobe programs only with master enable
// R9: Software sets strobe within four cycles
// R10: Hardware clears write strobe when programming ends
// R11: Programming lasts 2048 RC oscillator cycles
// R12: Write strobe stalls CPU four cycles
// R13: Read strobe fetches byte, then self-clears
// R14: Read strobe stalls CPU two cycles
// R15: During write: no read, no address change
// R16: Software checks write strobe before reading
// R17: Software masks interrupts during write sequence
// R18: Reset does not abort a running write
// R19: Rewriting master enable restarts its count
`timescale 1ns/10ps
`default_nettype none
`include "eeac_defines.vh"

module eeac_controller (
  // Clock and resets
  input wire core_clk,
  input wire reset_n,
  input wire por_n,
  // CPU I/O bus
  input wire [5:0] io_addr,
  input wire io_write,
  input wire io_read,
  input wire [7:0] io_wdata,
  output reg [7:0] io_rdata,
  // CPU interface
  input wire global_irq_enable,
  output wire ready_irq,
  output wire cpu_stall,
  // Calibrated RC oscillator divider setting
  input wire [`EEAC_RC_DIV_WIDTH-1:0] rc_div,
  // Nonvolatile array
  output reg [8:0] nv_addr_out,
  output reg [7:0] nv_wdata,
  output reg nv_write_req,
  input wire [7:0] nv_rdata
);

  // ****************************************
  // State
  // ****************************************
  localparam ST_IDLE = 2'b01;
  localparam ST_PROG = 2'b10;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [8:0] nv_address_q;
  reg [7:0] nv_data_q;
  reg ready_irq_enable_q;
  reg master_write_enable_q;
  reg read_strobe_q;
  reg [11:0] prog_count_q;
  reg [`EEAC_RC_DIV_WIDTH-1:0] rc_div_q;
  reg rc_tick_q;

  wire write_busy;
  wire sel_control;
  wire sel_data;
  wire sel_addr_low;
  wire sel_addr_high;
  wire write_start;
  wire read_start;
  wire master_set;
  wire master_done;
  wire stall_write_busy;
  wire stall_read_busy;
  wire prog_done;

  assign write_busy = (state_q == ST_PROG);
  assign sel_control = (io_addr == `EEAC_ADDR_CONTROL);
  assign sel_data = (io_addr == `EEAC_ADDR_DATA);
  assign sel_addr_low = (io_addr == `EEAC_ADDR_ADDRESS_LOW);
  assign sel_addr_high = (io_addr == `EEAC_ADDR_ADDRESS_HIGH);

  assign master_set = io_write && sel_control && io_wdata[`EEAC_BIT_MASTER];
  assign write_start = io_write && sel_control && io_wdata[`EEAC_BIT_WRITE]
    && master_write_enable_q && !write_busy; // see R8
  assign read_start = io_write && sel_control && io_wdata[`EEAC_BIT_READ]
    && !write_busy; // see R15

  // ****************************************
  // Master write enable expiry
  // ****************************************
  // Reload on every set so a second write restarts the window
  eeac_countdown #(
    .WIDTH(3)
  ) u_master_timer (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .load(master_set), // see R19
    .load_value(`EEAC_MASTER_CYCLES),
    .step(1'b1),
    .busy(),
    .done(master_done) // see R7
  );

  // ****************************************
  // CPU stall timers
  // ****************************************
  eeac_countdown #(
    .WIDTH(3)
  ) u_write_stall (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .load(write_start),
    .load_value(`EEAC_WRITE_STALL), // see R12
    .step(1'b1),
    .busy(stall_write_busy),
    .done()
  );

  eeac_countdown #(
    .WIDTH(3)
  ) u_read_stall (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .load(read_start),
    .load_value(`EEAC_READ_STALL), // see R14
    .step(1'b1),
    .busy(stall_read_busy),
    .done()
  );

  assign cpu_stall = stall_write_busy || stall_read_busy;

  // ****************************************
  // RC oscillator tick divider
  // ****************************************
  // Stands in for the calibrated oscillator; runs on por_n only
  always @(posedge core_clk or negedge por_n) begin
    if (!por_n) begin
      rc_div_q <= {`EEAC_RC_DIV_WIDTH{1'b0}};
      rc_tick_q <= 1'b0;
    end else if (rc_div_q >= rc_div) begin
      rc_div_q <= {`EEAC_RC_DIV_WIDTH{1'b0}};
      rc_tick_q <= 1'b1;
    end else begin
      rc_div_q <= rc_div_q + {{(`EEAC_RC_DIV_WIDTH-1){1'b0}}, 1'b1};
      rc_tick_q <= 1'b0;
    end
  end

  // ****************************************
  // Programming sequencer
  // ****************************************
  // Kept on power-on reset only: a system reset must not cut a write short
  assign prog_done = write_busy && rc_tick_q && (prog_count_q == 12'h000); // see R11

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (write_start) begin
          state_d = ST_PROG;
        end
      end
      ST_PROG: begin
        if (prog_done) begin
          state_d = ST_IDLE; // see R10
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge core_clk or negedge por_n) begin
    if (!por_n) begin
      state_q <= ST_IDLE;
      prog_count_q <= 12'h000;
      nv_write_req <= 1'b0;
      nv_addr_out <= 9'h000;
      nv_wdata <= 8'h00;
    end else begin
      state_q <= state_d; // see R18
      nv_write_req <= prog_done;
      if (write_start && !write_busy) begin
        prog_count_q <= `EEAC_PROG_RC_CYCLES; // see R11
        nv_addr_out <= nv_address_q;
        nv_wdata <= nv_data_q; // see R4
      end else if (write_busy && rc_tick_q && prog_count_q != 12'h000) begin
        prog_count_q <= prog_count_q - 12'h001;
      end
      if (read_start) begin
        nv_addr_out <= nv_address_q;
      end
    end
  end

  // ****************************************
  // Address and data registers
  // ****************************************
  // No reset: contents undefined until software loads them
  always @(posedge core_clk) begin
    if (io_write && sel_addr_low && !write_busy) begin
      nv_address_q[7:0] <= io_wdata; // see R15
    end
    if (io_write && sel_addr_high && !write_busy) begin
      nv_address_q[8] <= io_wdata[0]; // see R1, R2, R3
    end
    // Array address is launched at the strobe edge, so the byte is
    // valid one cycle later; the read stall hides that extra cycle
    if (read_strobe_q) begin
      nv_data_q <= nv_rdata; // see R13
    end else if (io_write && sel_data) begin
      nv_data_q <= io_wdata;
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ready_irq_enable_q <= 1'b0;
      master_write_enable_q <= 1'b0;
      read_strobe_q <= 1'b0;
    end else begin
      if (io_write && sel_control) begin
        ready_irq_enable_q <= io_wdata[`EEAC_BIT_IRQ_EN];
      end
      if (master_set) begin
        master_write_enable_q <= 1'b1;
      end else if (master_done) begin
        master_write_enable_q <= 1'b0; // see R7
      end
      // Byte is fetched one cycle after the strobe, at the edge that drops the flag, so the flag lasts one cycle
      read_strobe_q <= read_start; // see R13
    end
  end

  assign ready_irq = ready_irq_enable_q && global_irq_enable && !write_busy; // see R6

  // ****************************************
  // Read mux
  // ****************************************
  // Unmapped addresses read zero
  always @* begin
    io_rdata = 8'h00;
    case (io_addr)
      `EEAC_ADDR_CONTROL: begin
        io_rdata = {4'h0, ready_irq_enable_q, master_write_enable_q,
          write_busy, read_strobe_q}; // see R5
      end
      `EEAC_ADDR_DATA: begin
        io_rdata = nv_data_q;
      end
      `EEAC_ADDR_ADDRESS_LOW: begin
        io_rdata = nv_address_q[7:0];
      end
      `EEAC_ADDR_ADDRESS_HIGH: begin
        io_rdata = {7'h00, nv_address_q[8]}; // see R2
      end
      default: begin
        io_rdata = 8'h00;
      end
    endcase
  end

endmodule // eeac_controller

`default_nettype wire

// *** eeac_defines.vh ***
// Constants for the nonvolatile data store access controller.
// Assumes an I/O bus with byte-wide data and 6-bit I/O addresses.
`ifndef EEAC_DEFINES_VH
`define EEAC_DEFINES_VH

// ****************************************
// Register addresses (I/O space)
// ****************************************
`define EEAC_ADDR_CONTROL 6'h1c
`define EEAC_ADDR_DATA 6'h1d
`define EEAC_ADDR_ADDRESS_LOW 6'h1e
`define EEAC_ADDR_ADDRESS_HIGH 6'h1f

// ****************************************
// Control register fields
// ****************************************
`define EEAC_BIT_READ 0
`define EEAC_BIT_WRITE 1
`define EEAC_BIT_MASTER 2
`define EEAC_BIT_IRQ_EN 3
`define EEAC_CONTROL_RESET 4'h0

// ****************************************
// Timing
// ****************************************
`define EEAC_MASTER_CYCLES 3'h4
`define EEAC_WRITE_STALL 3'h4
`define EEAC_READ_STALL 3'h2
`define EEAC_PROG_RC_CYCLES 12'h7ff
`define EEAC_RC_DIV_WIDTH 8
`define EEAC_RC_DIV_DEFAULT 8'h1f
`define EEAC_NV_DEPTH 512

`endif

// *** eeac_countdown.v ***
// Loadable down counter with a terminal-count pulse.
// Assumes a single clock and an active-low asynchronous reset.
`timescale 1ns/10ps
`default_nettype none

module eeac_countdown #(
  parameter WIDTH = 3
) (
  // Clock and reset
  input wire core_clk,
  input wire reset_n,
  // Control
  input wire load,
  input wire [WIDTH-1:0] load_value,
  input wire step,
  // Status
  output wire busy,
  output wire done
);
  reg [WIDTH-1:0] count_q;
  reg [WIDTH-1:0] count_d;

  assign busy = (count_q != {WIDTH{1'b0}});
  assign done = busy && step && (count_q == {{(WIDTH-1){1'b0}}, 1'b1}) && !load;

  always @* begin
    count_d = count_q;
    if (load) begin
      count_d = load_value;
    end else if (busy && step) begin
      count_d = count_q - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= {WIDTH{1'b0}};
    end else begin
      count_q <= count_d;
    end
  end
endmodule // eeac_countdown

`default_nettype wire

// *** eeac_nv_model.sv ***
// Behavioural model of the 512-byte array.
// Assumes the controller's one-cycle commit pulse.
`timescale 1ns/10ps
`default_nettype none
module eeac_nv_model (
  // Clock
  input wire logic core_clk,
  // Array port
  input wire logic [8:0] nv_addr_out,
  input wire logic [7:0] nv_wdata,
  input wire logic nv_write_req,
  output logic [7:0] nv_rdata
);
  // Unwritten bytes stay unknown, as in a fresh part
  logic [7:0] mem_q [0:511];
  always @(posedge core_clk) begin
    if (nv_write_req) begin
      mem_q[nv_addr_out] <= nv_wdata;
    end
  end
  assign nv_rdata = mem_q[nv_addr_out];
endmodule // eeac_nv_model
`default_nettype wire

// *** eeac_controller_monitor.sv ***
// Port checker for the access controller.
// Assumes it is bound to every eeac_controller.
`timescale 1ns/10ps
`default_nettype none
module eeac_monitor (
  // Clock and resets
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic por_n,
  // I/O bus
  input wire logic [5:0] io_addr,
  input wire logic io_write,
  input wire logic io_read,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  // CPU side
  input wire logic global_irq_enable,
  input wire logic ready_irq,
  input wire logic cpu_stall,
  input wire logic [7:0] rc_div,
  // Array side
  input wire logic [8:0] nv_addr_out,
  input wire logic [7:0] nv_wdata,
  input wire logic nv_write_req,
  input wire logic [7:0] nv_rdata
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic c;
  logic [7:0] w;
  assign c = io_addr == 6'h1c;
  assign w = (io_write && c) ? io_wdata : 8'h00;
  a_ctl_upper_zero: assert property (c |-> io_rdata[7:4] == 4'h0)
    else $error("control upper bits set");
  a_addr_upper_zero: assert property (io_addr == 6'h1f |-> io_rdata[7:1] == 7'h00)
    else $error("address upper bits set");
  a_ready_level: assert property (c |-> ready_irq == (io_rdata[3] & global_irq_enable
    & !io_rdata[1])) else $error("ready interrupt wrong");
  a_read_stall: assert property (w == 8'h01 && !io_rdata[1] && !cpu_stall |=>
    cpu_stall [*2] ##1 !cpu_stall) else $error("read stall length wrong");
  a_write_stall: assert property (w[1] && !w[0] && io_rdata[2] && !io_rdata[1] && !cpu_stall
    |=> cpu_stall [*4] ##1 !cpu_stall) else $error("write stall length wrong");
  a_strobe_refused: assert property (w[1] && !w[2] && !w[0] && !io_rdata[2] && !io_rdata[1]
    && !cpu_stall |=> !cpu_stall) else $error("write started without master");
  a_master_set: assert property (w[2] && !w[1] ##1 c |-> io_rdata[2])
    else $error("master enable not set");
  a_master_expiry: assert property (w[2] && !w[1] ##1 (c && !io_write) [*5]
    |-> !io_rdata[2]) else $error("master enable did not expire");
  a_strobe_clears: assert property (nv_write_req ##1 c |-> !io_rdata[1])
    else $error("write bit kept after commit");
endmodule // eeac_monitor
bind eeac_controller eeac_monitor eeac_monitor_i (.core_clk(core_clk), .reset_n(reset_n),
  .por_n(por_n), .io_addr(io_addr), .io_write(io_write), .io_read(io_read),
  .io_wdata(io_wdata), .io_rdata(io_rdata), .global_irq_enable(global_irq_enable),
  .ready_irq(ready_irq), .cpu_stall(cpu_stall), .rc_div(rc_div), .nv_addr_out(nv_addr_out),
  .nv_wdata(nv_wdata), .nv_write_req(nv_write_req), .nv_rdata(nv_rdata));
`default_nettype wire

// *** eeac_controller_tb.sv ***
// Self-checking bench for the access controller.
// Assumes the array model and the bound port checker.
`timescale 1ns/10ps
`default_nettype none
module eeac_controller_tb;
  logic core_clk = 1'b0, reset_n = 1'b0, por_n = 1'b0, io_write = 1'b0, io_read = 1'b0;
  logic global_irq_enable = 1'b0, ready_irq, cpu_stall, nv_write_req;
  logic [5:0] io_addr = 6'h00;
  logic [7:0] io_wdata = 8'h00, io_rdata, nv_wdata, nv_rdata, v;
  logic [8:0] nv_addr_out, a;
  logic [7:0] exp_mem [0:511];
  logic [31:0] lfsr = 32'h0949;
  int num_errors = 0, checks_done = 0, n;
  time t0;
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  // Fastest RC tick so a write lasts 2048 core cycles
  eeac_controller eeac_controller_i (.core_clk(core_clk), .reset_n(reset_n), .por_n(por_n),
    .io_addr(io_addr), .io_write(io_write), .io_read(io_read), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .global_irq_enable(global_irq_enable), .ready_irq(ready_irq),
    .cpu_stall(cpu_stall), .rc_div(8'h00), .nv_addr_out(nv_addr_out), .nv_wdata(nv_wdata),
    .nv_write_req(nv_write_req), .nv_rdata(nv_rdata));
  eeac_nv_model eeac_nv_model_i (.core_clk(core_clk), .nv_addr_out(nv_addr_out),
    .nv_wdata(nv_wdata), .nv_write_req(nv_write_req), .nv_rdata(nv_rdata));
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] ad, input logic [7:0] d);
    @(posedge core_clk);
    io_addr <= ad;
    io_wdata <= d;
    io_write <= 1'b1;
    io_read <= 1'b0;
    @(posedge core_clk);
    io_write <= 1'b0;
  endtask
  // Read data is combinational, so sample once the edge has settled
  task automatic rd(input logic [5:0] ad);
    @(posedge core_clk);
    io_addr <= ad;
    io_read <= 1'b1;
    #1 v = io_rdata;
  endtask
  task automatic set_addr(input logic [8:0] ad);
    wr(6'h1e, ad[7:0]);
    wr(6'h1f, {lfsr[23:17], ad[8]});
  endtask
  task automatic write_byte(input logic [8:0] ad, input logic [7:0] d, input logic rst);
    set_addr(ad);
    wr(6'h1d, d);
    global_irq_enable <= 1'b0;
    wr(6'h1c, 8'h0c);
    rd(6'h1c);
    wr(6'h1c, 8'h0c);
    wr(6'h1c, 8'h0e);
    global_irq_enable <= 1'b1;
    t0 = $time;
    exp_mem[ad] = d;
    repeat (4) @(posedge core_clk);
    if (rst) begin
      @(posedge core_clk) reset_n <= 1'b0;
      @(posedge core_clk) reset_n <= 1'b1;
    end
    wr(6'h1e, ~ad[7:0]);
    wr(6'h1c, 8'h09);
    rd(6'h1e);
    cmp({8'h00, v}, {8'h00, ad[7:0]});
    rd(6'h1c);
    cmp({8'h00, v}, 16'h000a);
    cmp({15'h0000, ready_irq}, 16'h0000);
    n = 0;
    do begin
      rd(6'h1c);
      n++;
    end while (v[1] === 1'b1 && n < 4000);
    n = int'(($time - t0) / 4);
    cmp(16'(n >= 2044 && n <= 2056), 16'h0001);
    cmp({15'h0000, ready_irq}, 16'h0001);
  endtask
  task automatic read_byte(input logic [8:0] ad);
    set_addr(ad);
    wr(6'h1c, 8'h01);
    repeat (2) @(posedge core_clk);
    rd(6'h1d);
    cmp({8'h00, v}, {8'h00, exp_mem[ad]});
    rd(6'h1c);
    cmp({8'h00, v}, 16'h0000);
  endtask
  task automatic final_report;
    $display("errors %0d, checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    final_report;
  end
  initial begin
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    por_n <= 1'b1;
    global_irq_enable <= 1'b1;
    rd(6'h1c);
    cmp({8'h00, v}, 16'h0000);
    wr(6'h1f, 8'hff);
    rd(6'h1f);
    cmp({8'h00, v}, 16'h0001);
    wr(6'h1c, 8'hf8);
    rd(6'h1c);
    cmp({8'h00, v}, 16'h0008);
    wr(6'h1c, 8'h0a);
    rd(6'h1c);
    cmp({8'h00, v}, 16'h0008);
    wr(6'h1c, 8'h0c);
    repeat (6) rd(6'h1c);
    wr(6'h1c, 8'h0a);
    rd(6'h1c);
    cmp({8'h00, v}, 16'h0008);
    for (int i = 0; i < 5; i++) begin
      lfsr = next_rand(lfsr);
      a = (i == 0) ? 9'h000 : (i == 1) ? 9'h1ff : lfsr[8:0];
      write_byte(a, lfsr[15:8], i == 4);
      read_byte(a);
    end
    final_report;
  end
endmodule // eeac_controller_tb
`default_nettype wire
